// ===== bench/host_pins_model.sv
/*
  host-side model: drives the three mode-select pins when asked.
  assumes the bench pulses go_in for one cycle with target_in valid.
*/
`timescale 1ns/1ns
// ============================================================
// host pins
module host_pins_model #(
  parameter int HOLD = 16
) (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       polite_in,
  input  wire logic [2:0] target_in,
  input  wire logic       busy_ready_in,
  output logic      [2:0] pins_out
);
  initial pins_out = 3'h0;
  always @(posedge clk_in) begin
    if (go_in === 1'b1) begin
      // a polite host waits for ready, then the settle margin
      if (polite_in) begin
        wait (busy_ready_in === 1'b1);
        repeat (HOLD) @(posedge clk_in);
      end
      #1 pins_out <= target_in;
    end
  end
endmodule

// ===== bench/test_mode_switch_ctrl.sv
/*
  self-checking bench for the mode-select controller.
  assumes short settle and report counts; host model owns the pins.
*/
`timescale 1ns/1ns
// ============================================================
// bench
module test_mode_switch_ctrl;
  import mode_switch_pkg::*;
  localparam int SC = 8;
  localparam int RC = 20;
  logic        clk_in = 0, rst_in = 1, done = 0, tx_p = 0, rx_p = 0, strm = 0;
  logic        go = 0, polite = 0, rx_v = 0;
  logic [2:0]  target = 0, baud = 0, field = 0, pins;
  logic [15:0] addr = 0;
  logic [7:0]  lvl = 0, rx_b = 0;
  logic        busy, sleep, txen, rxen, bc, rs_v, u_v;
  logic [2:0]  mode, air;
  logic [7:0]  rs_b, u_b;
  int          errors = 0;
  int          n_compared = 0;

  always #5 clk_in = ~clk_in;

  host_pins_model #(.HOLD(2 * SC)) u_host (.clk_in(clk_in), .go_in(go), .polite_in(polite),
    .target_in(target), .busy_ready_in(busy), .pins_out(pins));

  mode_switch_ctrl #(.SETTLE_CNT(SC), .RSSI_CNT(RC)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .mode_sel_bit0_in(pins[0]), .mode_sel_bit1_in(pins[1]), .mode_sel_bit2_in(pins[2]),
    .selfcheck_done_in(done), .tx_pending_in(tx_p), .rx_pending_in(rx_p),
    .host_streaming_in(strm), .baud_sel_in(baud), .air_rate_field_in(field),
    .node_addr_in(addr), .rssi_level_in(lvl), .rx_byte_in(rx_b), .rx_byte_valid_in(rx_v),
    .busy_ready_out(busy), .active_mode_out(mode), .sleep_out(sleep),
    .radio_tx_en_out(txen), .radio_rx_en_out(rxen), .air_rate_out(air),
    .broadcast_out(bc), .rssi_byte_out(rs_b), .rssi_valid_out(rs_v),
    .uart_byte_out(u_b), .uart_valid_out(u_v));

  // ============================================================
  // helpers
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic bad(input string m);
    errors++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic cmp_bit(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e) bad(m);
  endtask
  task automatic cmp_mode(input logic [2:0] g, input logic [2:0] e, input string m);
    n_compared++;
    if (g !== e) bad(m);
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) bad(m);
  endtask
  task automatic cmp_span(input int g, input int lo, input int hi, input string m);
    n_compared++;
    if (g < lo || g > hi) bad(m);
  endtask
  task automatic request(input logic [2:0] m, input logic pol);
    target = m;
    polite = pol;
    go = 1;
    tick();
    go = 0;
  endtask
  task automatic wait_mode(input logic [2:0] m, output int n);
    n = 0;
    while (mode !== m && n < 400) begin
      tick();
      n++;
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ============================================================
  // scenarios
  task automatic t_power_up();
    tick(6);
    cmp_bit(busy, 0, "busy in reset");
    rst_in = 0;
    tick(8);
    cmp_bit(busy, 0, "busy before self-check");
    done = 1;
    tick(3);
    cmp_bit(busy, 1, "ready after self-check");
    cmp_mode(mode, MODE_RSSI, "mode from pins 000");
  endtask
  task automatic t_rssi();
    int n;
    lvl = 8'h5A;
    field = 3'h6;
    n = 0;
    while (rs_v !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    cmp_byte(rs_b, 8'h5A, "noise byte");
    lvl = 8'hA5;
    n = 0;
    do begin
      tick();
      n++;
      cmp_bit(txen | rxen, 0, "radio on in report mode");
    end while (rs_v !== 1'b1 && n < 60);
    cmp_span(n, RC, RC, "report period");
    cmp_byte(rs_b, 8'hA5, "noise byte update");
    cmp_mode(air, 3'h6, "air rate field outside mode 1");
  endtask
  task automatic t_idle_switch();
    int n;
    request(MODE_CONT, 0);
    wait_mode(MODE_CONT, n);
    cmp_span(n, SC + 2, SC + 7, "idle switch delay");
    cmp_bit(txen & rxen, 1, "radio enables in mode 1");
  endtask
  task automatic t_air_rate();
    field = 3'h7;
    for (int b = 0; b < 8; b++) begin
      baud = b[2:0];
      tick();
      cmp_mode(air, (b < 3) ? 3'h0 : 3'(b - 2), "air rate from baud");
    end
  endtask
  task automatic t_rx_stream();
    for (int i = 0; i < 4; i++) begin
      rx_b = 8'h10 + 8'(i);
      rx_v = 1;
      tick();
      cmp_bit(u_v, 1, "stream gap");
      cmp_byte(u_b, 8'h10 + 8'(i), "stream byte");
    end
    rx_v = 0;
    tick();
    cmp_bit(u_v, 0, "stream extra byte");
  endtask
  task automatic t_defer(input bit use_rx, input logic [2:0] from, input logic [2:0] to);
    int n;
    if (use_rx) rx_p = 1;
    else tx_p = 1;
    tick(2);
    cmp_bit(busy, 0, "busy while pending");
    request(to, 0);
    tick(3 * SC);
    cmp_mode(mode, from, "switched while pending");
    rx_p = 0;
    tx_p = 0;
    wait_mode(to, n);
    cmp_span(n, SC, SC + 3, "deferred switch delay");
    cmp_bit(busy, 1, "ready after drain");
  endtask
  task automatic t_stream_block();
    int n;
    request(MODE_SUBPKT, 1);
    wait_mode(MODE_SUBPKT, n);
    cmp_span(n, 3 * SC + 2, 3 * SC + 7, "polite host switch");
    strm = 1;
    tick(2);
    cmp_bit(busy, 0, "busy while streaming");
    request(MODE_CONT, 0);
    tick(3 * SC);
    cmp_mode(mode, MODE_SUBPKT, "switched while streaming");
    strm = 0;
    wait_mode(MODE_CONT, n);
    cmp_span(n, SC, SC + 3, "switch after stream");
  endtask
  task automatic t_sleep();
    int n;
    tx_p = 1;
    request(MODE_SLEEP, 0);
    tick(3 * SC);
    cmp_bit(sleep, 0, "slept with data pending");
    tx_p = 0;
    wait_mode(MODE_SLEEP, n);
    cmp_span(n, SC, SC + 3, "sleep entry delay");
    cmp_bit(sleep, 1, "sleep flag");
    request(MODE_SAVE, 0);
    wait_mode(MODE_SAVE, n);
    cmp_span(n, SC + 2, SC + 7, "wake delay");
    cmp_bit(sleep, 0, "still asleep");
    cmp_mode({sleep, txen, rxen}, 3'h1, "enables in mode 6");
  endtask
  task automatic t_bcast();
    logic [15:0] a [5] = '{16'h0000, 16'hFFFF, 16'h0001, 16'hFFFE, 16'h1234};
    for (int i = 0; i < 5; i++) begin
      addr = a[i];
      tick();
      cmp_bit(bc, i < 2, "broadcast decode");
    end
  endtask

  // ============================================================
  // sequence and watchdog
  initial begin
    t_power_up();
    t_rssi();
    t_idle_switch();
    t_air_rate();
    t_rx_stream();
    t_defer(0, MODE_CONT, MODE_RSSI);
    t_defer(1, MODE_RSSI, MODE_CONT);
    t_stream_block();
    t_sleep();
    t_bcast();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    bad("watchdog expired");
    conclude();
  end
endmodule

// ===== rtl/mode_switch_ctrl.sv
/*
  mode-select controller: picks the operating mode from three pins, defers
  a change while data is pending, drives the busy/ready indicator, emits
  the periodic noise byte in report mode and sets radio enables, air rate
  and broadcast status.
  assumes the datapath reports pending tx/rx data and self-check completion,
  and that a uart outside this block serialises the bytes presented here.
*/
`timescale 1ns/1ns
module mode_switch_ctrl
  import mode_switch_pkg::*;
#(
  parameter int SETTLE_CNT = SETTLE_CYCLES,
  parameter int RSSI_CNT   = RSSI_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        mode_sel_bit0_in,
  input  wire logic        mode_sel_bit1_in,
  input  wire logic        mode_sel_bit2_in,
  input  wire logic        selfcheck_done_in,
  input  wire logic        tx_pending_in,
  input  wire logic        rx_pending_in,
  input  wire logic        host_streaming_in,
  input  wire logic [2:0]  baud_sel_in,
  input  wire logic [2:0]  air_rate_field_in,
  input  wire logic [15:0] node_addr_in,
  input  wire logic [7:0]  rssi_level_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_byte_valid_in,
  output logic             busy_ready_out,
  output logic      [2:0]  active_mode_out,
  output logic             sleep_out,
  output logic             radio_tx_en_out,
  output logic             radio_rx_en_out,
  output logic      [2:0]  air_rate_out,
  output logic             broadcast_out,
  output logic      [7:0]  rssi_byte_out,
  output logic             rssi_valid_out,
  output logic      [7:0]  uart_byte_out,
  output logic             uart_valid_out
);

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CNT - 1);
  localparam logic [CNT_W-1:0] RSSI_LAST   = CNT_W'(RSSI_CNT - 1);

  logic [2:0]       req_mode;
  logic [2:0]       prev_pins_r;
  logic             pending;
  logic             operating;
  logic [2:0]       falling;
  sw_state_e        state_r;
  sw_state_e        state_nxt;
  logic [2:0]       active_r;
  logic [2:0]       active_nxt;
  logic [CNT_W-1:0] settle_r;
  logic [CNT_W-1:0] settle_nxt;
  logic [CNT_W-1:0] rcnt_r;
  logic [CNT_W-1:0] rcnt_nxt;
  logic             busy_r;
  logic             busy_nxt;
  logic [7:0]       rssi_byte_r;
  logic [7:0]       rssi_byte_nxt;
  logic             rssi_valid_r;
  logic             rssi_valid_nxt;
  logic [7:0]       uart_byte_r;
  logic [7:0]       uart_byte_nxt;
  logic             uart_valid_r;
  logic             uart_valid_nxt;
  logic             tx_en;
  logic             rx_en;

  // ==========================================================================
  // pin capture
  pin_sync u_pin_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pins_in   ({mode_sel_bit2_in, mode_sel_bit1_in, mode_sel_bit0_in}),
    .level_out (req_mode)
  );

  // streaming input in the sub-package and wake modes counts as unfinished work
  assign pending   = tx_pending_in | rx_pending_in
                   | (host_streaming_in & ((active_r == MODE_SUBPKT)
                                         | (active_r == MODE_WAKE)));
  assign falling   = prev_pins_r & ~req_mode;
  assign operating = (state_r == ST_RUN) | (state_r == ST_DEFER) | (state_r == ST_SETTLE);

  // ==========================================================================
  // mode sequencer
  always_comb begin
    state_nxt  = state_r;
    active_nxt = active_r;
    settle_nxt = settle_r;
    case (state_r)
      ST_INIT: begin
        if (selfcheck_done_in) begin
          active_nxt = req_mode;
          state_nxt  = (req_mode == MODE_SLEEP) ? ST_SLEEP : ST_RUN;
        end
      end
      ST_RUN: begin
        settle_nxt = '0;
        if (req_mode != active_r) begin
          state_nxt = pending ? ST_DEFER : ST_SETTLE;
        end
      end
      ST_DEFER: begin
        settle_nxt = '0;
        if (req_mode == active_r) begin
          state_nxt = ST_RUN;
        end else if (!pending) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // pins that return to the running mode cancel the change
        if (req_mode == active_r) begin
          state_nxt = ST_RUN;
        end else if (pending) begin
          state_nxt = ST_DEFER;
        end else if (settle_r == SETTLE_LAST) begin
          active_nxt = req_mode;
          state_nxt  = (req_mode == MODE_SLEEP) ? ST_SLEEP : ST_RUN;
        end else begin
          settle_nxt = settle_r + 1'b1;
        end
      end
      ST_SLEEP: begin
        settle_nxt = '0;
        if (|falling) begin
          state_nxt = ST_SETTLE;
        end
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase
  end

  // ==========================================================================
  // indicator, noise report and receive stream
  always_comb begin
    busy_nxt       = (state_nxt != ST_INIT) & ~pending;
    rcnt_nxt       = '0;
    rssi_valid_nxt = 1'b0;
    rssi_byte_nxt  = rssi_byte_r;
    if (operating && (active_r == MODE_RSSI)) begin
      if (rcnt_r == RSSI_LAST) begin
        rssi_valid_nxt = 1'b1;
        rssi_byte_nxt  = rssi_level_in;
      end else begin
        rcnt_nxt = rcnt_r + 1'b1;
      end
    end
    // bytes pass straight through, so no packet boundary opens a gap
    uart_valid_nxt = rx_byte_valid_in & rx_en;
    uart_byte_nxt  = rx_byte_valid_in ? rx_byte_in : uart_byte_r;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r      <= ST_INIT;
      active_r     <= MODE_RSSI;
      settle_r     <= '0;
      rcnt_r       <= '0;
      busy_r       <= 1'b0;
      rssi_byte_r  <= 8'h00;
      rssi_valid_r <= 1'b0;
      uart_byte_r  <= 8'h00;
      uart_valid_r <= 1'b0;
      prev_pins_r  <= PIN_RESET;
    end else begin
      state_r      <= state_nxt;
      active_r     <= active_nxt;
      settle_r     <= settle_nxt;
      rcnt_r       <= rcnt_nxt;
      busy_r       <= busy_nxt;
      rssi_byte_r  <= rssi_byte_nxt;
      rssi_valid_r <= rssi_valid_nxt;
      uart_byte_r  <= uart_byte_nxt;
      uart_valid_r <= uart_valid_nxt;
      prev_pins_r  <= req_mode;
    end
  end

  // ==========================================================================
  // radio enables and air rate per mode
  always_comb begin
    tx_en = 1'b0;
    rx_en = 1'b0;
    if (operating) begin
      case (active_r)
        MODE_CONT, MODE_SUBPKT: begin
          tx_en = 1'b1;
          rx_en = 1'b1;
        end
        MODE_WAKE: tx_en = 1'b1;
        MODE_SAVE: rx_en = 1'b1;
        default: begin
          tx_en = 1'b0;
          rx_en = 1'b0;
        end
      endcase
    end
  end

  assign air_rate_out    = (active_r == MODE_CONT) ? air_rate_for_baud(baud_sel_in)
                                                   : air_rate_field_in;
  assign broadcast_out   = (node_addr_in == BCAST_ADDR_LO)
                         | (node_addr_in == BCAST_ADDR_HI);
  assign radio_tx_en_out = tx_en;
  assign radio_rx_en_out = rx_en;
  assign busy_ready_out  = busy_r;
  assign active_mode_out = active_r;
  assign sleep_out       = (state_r == ST_SLEEP);
  assign rssi_byte_out   = rssi_byte_r;
  assign rssi_valid_out  = rssi_valid_r;
  assign uart_byte_out   = uart_byte_r;
  assign uart_valid_out  = uart_valid_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_busy_selfcheck: assert property (state_r == ST_INIT |-> !busy_ready_out)
    else $error("indicator high before self-check done");
  chk_busy_pending: assert property (tx_pending_in | rx_pending_in |=> !busy_ready_out)
    else $error("indicator high while data pending");
  chk_mode_hold: assert property (pending && state_r != ST_INIT |=> $stable(active_r))
    else $error("mode changed while data pending");
  chk_settle_time: assert property ($changed(active_r) && $past(state_r) != ST_INIT
      |-> $past(state_r) == ST_SETTLE && $past(settle_r) == SETTLE_LAST)
    else $error("mode applied without full settle delay");
  chk_settle_bound: assert property (state_r == ST_SETTLE |-> settle_r <= SETTLE_LAST)
    else $error("settle counter overran");
  chk_report_radio: assert property (active_r == MODE_RSSI
      |-> !radio_tx_en_out && !radio_rx_en_out)
    else $error("radio enabled in report mode");
  chk_cont_radio: assert property (active_r == MODE_CONT && state_r == ST_RUN
      |-> radio_tx_en_out && radio_rx_en_out)
    else $error("radio disabled in continuous mode");
  chk_report_pulse: assert property (rssi_valid_out
      |-> $past(active_r) == MODE_RSSI ##1 !rssi_valid_out)
    else $error("noise byte outside report mode or too long");
  chk_report_spacing: assert property (rcnt_r == RSSI_LAST && operating
      && active_r == MODE_RSSI |=> rssi_valid_out && rssi_byte_out == $past(rssi_level_in))
    else $error("noise byte not on period");
  chk_air_auto: assert property (active_r == MODE_CONT
      |-> air_rate_out == air_rate_for_baud(baud_sel_in))
    else $error("air rate field used in continuous mode");
  chk_bcast_addr: assert property (node_addr_in == BCAST_ADDR_HI |-> broadcast_out)
    else $error("all-ones address not broadcast");
  chk_sleep_entry: assert property ($rose(sleep_out) && $past(state_r) != ST_INIT
      |-> $past(state_r) == ST_SETTLE && !$past(pending))
    else $error("sleep entered with data pending");
  chk_wake_edge: assert property (state_r == ST_SLEEP && |falling |=> state_r == ST_SETTLE)
    else $error("falling pin did not wake");
  chk_rx_stream: assert property (rx_byte_valid_in && rx_en |=> uart_valid_out
      && uart_byte_out == $past(rx_byte_in))
    else $error("received byte not forwarded");

  cov_deferred: cover property (state_r == ST_DEFER ##1 state_r == ST_SETTLE);
  cov_sleep: cover property ($rose(sleep_out));
  cov_report: cover property (rssi_valid_out);
  cov_wake: cover property (state_r == ST_SLEEP ##1 state_r == ST_SETTLE);

endmodule

// ===== rtl/mode_switch_pkg.sv
/*
  shared constants for the mode-select controller: mode codes, controller
  states, broadcast addresses and the settle / report timing.
  assumes a 100 MHz system clock.
*/
package mode_switch_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SETTLE_TIME_US  = 1000;    // 1 ms
  localparam int RSSI_PERIOD_US  = 100000;  // 100 ms
  localparam int SETTLE_CYCLES   = SETTLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int RSSI_CYCLES     = RSSI_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W           = 24;

  // ==========================================================================
  // mode codes, value of {bit2, bit1, bit0}
  localparam logic [2:0] MODE_RSSI   = 3'h0;
  localparam logic [2:0] MODE_CONT   = 3'h1;
  localparam logic [2:0] MODE_SUBPKT = 3'h2;
  localparam logic [2:0] MODE_WAKE   = 3'h4;
  localparam logic [2:0] MODE_SAVE   = 3'h6;
  localparam logic [2:0] MODE_SLEEP  = 3'h7;
  localparam logic [2:0] PIN_RESET   = 3'h0;

  // ==========================================================================
  // addressing
  localparam logic [15:0] BCAST_ADDR_LO = 16'h0000;
  localparam logic [15:0] BCAST_ADDR_HI = 16'hFFFF;

  typedef enum logic [2:0] {ST_INIT, ST_RUN, ST_DEFER, ST_SETTLE, ST_SLEEP} sw_state_e;

  // ==========================================================================
  // air rate chosen from the uart baud code; never falls as baud rises
  function automatic logic [2:0] air_rate_for_baud(input logic [2:0] baud);
    logic [2:0] r;
    r = 3'h0;
    case (baud)
      3'h0, 3'h1, 3'h2: r = 3'h0;
      3'h3:             r = 3'h1;
      3'h4:             r = 3'h2;
      3'h5:             r = 3'h3;
      3'h6:             r = 3'h4;
      default:          r = 3'h5;
    endcase
    return r;
  endfunction

endpackage

// ===== rtl/pin_sync.sv
/*
  three-stage synchroniser for the mode-select pins.
  assumes the pins are asynchronous to clk_in; a new level is accepted only
  when the second and third stages agree.
*/
`timescale 1ns/1ns
module pin_sync
  import mode_switch_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] pins_in,
  output logic      [2:0] level_out
);

  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] level_r;
  logic [2:0] level_nxt;

  // ==========================================================================
  // acceptance
  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r    <= PIN_RESET;
      s2_r    <= PIN_RESET;
      s3_r    <= PIN_RESET;
      level_r <= PIN_RESET;
    end else begin
      s1_r    <= pins_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule
